// [shared/pmp_cfg.svh]
// Constants for the program memory partition map
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH
`define PMP_PM_WORDS 4096
`define PMP_RESET_VEC 15'h0000
`define PMP_INT_VEC 15'h0004
`define PMP_PC_ONE 15'h0001
`define PMP_SAF_SPAN 15'h007F
`define PMP_PTR_PM_BIT 7
`define PMP_BB_END_111 15'h01FF
`define PMP_BB_END_110 15'h03FF
`define PMP_BB_END_101 15'h07FF
`define PMP_BB_END_100 15'h0FFF
`define PMP_BB_END_011 15'h1FFF
`define PMP_BB_END_LOW 15'h3FFF
`define PMP_CFG_LO 15'h0007
`define PMP_CFG_HI 15'h000B
`define PMP_DIA_FID_LAST 5'h08
`define PMP_DIA_CID_FIRST 5'h0A
`define PMP_DIA_CID_LAST 5'h11
`define PMP_DIA_REF1X 5'h18
`define PMP_DIA_REF2X 5'h19
`define PMP_DIA_REF4X 5'h1A
`define PMP_OFS_CTRL 8'h00
`define PMP_OFS_STATUS 8'h04
`define PMP_OFS_BOOTEND 8'h08
`define PMP_OFS_PC 8'h0C
`define PMP_DIA_WIN_BIT 7
`define PMP_B_BOOT_BLOCK_SIZE_SEL 0
`define PMP_B_BOOT_EN_N 3
`define PMP_B_SAF_EN_N 4
`define PMP_B_APP_WP_N 7
`define PMP_B_BOOT_WP_N 8
`define PMP_B_CFG_WP_N 9
`define PMP_B_BULK 31
`define PMP_B_WERR 0
`define PMP_B_EXEC 1
`define PMP_BOOT_BLOCK_SIZE_SEL_RST 3'h7
`define PMP_RESP_OKAY 2'h0
`define PMP_RESP_SLVERR 2'h2
`endif

// [shared/pmp_pkg.sv]
// Types for the program memory partition map
package pmp_pkg;
  typedef enum logic [1:0] {
    PMP_IND_IDLE = 2'b01,
    PMP_IND_FETCH = 2'b10
  } pmp_ind_type;

  typedef struct packed {
    logic [14:0] pc;
    logic [14:0] fetch_addr;
    logic [2:0] boot_block_size_sel;
    logic boot_en_n;
    logic saf_en_n;
    logic app_wp_n;
    logic boot_wp_n;
    logic cfg_wp_n;
    logic wr_err;
    logic exec_ok;
    logic viol_rst;
    logic flash_rd;
    logic [14:0] flash_addr;
    logic flash_wr;
    logic [15:0] flash_wr_addr;
    logic [13:0] flash_wdata;
    pmp_ind_type ind;
    logic [7:0] ind_rdata;
    logic ind_done;
    logic ind_stall;
    logic ind_wr_drop;
    logic awok;
    logic awrdy;
    logic [7:0] awaddr;
    logic wok;
    logic wrdy;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pmp_state_type;
endpackage

// [rtl/pmp_region_decode.sv]
// Classifies a program address into its partition
`timescale 1ns/10ps
`include "pmp_cfg.svh"
module pmp_region_decode #(
  parameter int PM_WORDS = `PMP_PM_WORDS
) (
  input wire logic [15:0] addr,
  input wire logic [14:0] boot_last,
  input wire logic boot_en_n,
  input wire logic saf_en_n,
  output logic in_app,
  output logic in_boot,
  output logic in_saf,
  output logic in_cfg,
  output logic in_ro
);
  localparam logic [14:0] PM_LAST = 15'(PM_WORDS - 1);
  localparam logic [14:0] SAF_BASE = PM_LAST - `PMP_SAF_SPAN;
  logic user;
  assign user = ~addr[15];
  assign in_saf = user & ~saf_en_n & (addr[14:0] >= SAF_BASE);
  assign in_boot = user & ~boot_en_n & ~in_saf & (addr[14:0] <= boot_last);
  assign in_app = user & ~in_saf & ~in_boot;
  assign in_cfg = addr[15] & (addr[14:0] >= `PMP_CFG_LO) &
                  (addr[14:0] <= `PMP_CFG_HI);
  assign in_ro = addr[15] & ~in_cfg;
endmodule

// [rtl/pmp_info_rom.sv]
// Read-only device information area contents
`timescale 1ns/10ps
`include "pmp_cfg.svh"
module pmp_info_rom #(
  // Arbitrary identifier values
  parameter logic [125:0] FACTORY_ID = {9{14'h1A5C}},
  parameter logic [111:0] CUSTOMER_ID = {8{14'h3FFF}},
  parameter logic [13:0] REF_MV_1X = 14'h0400,
  parameter logic [13:0] REF_MV_2X = 14'h0800,
  parameter logic [13:0] REF_MV_4X = 14'h1000
) (
  input wire logic [4:0] idx,
  output logic [13:0] data
);
  logic [4:0] cid;
  assign cid = idx - `PMP_DIA_CID_FIRST;
  always_comb begin
    data = 14'h0000;
    if (idx <= `PMP_DIA_FID_LAST) begin
      data = FACTORY_ID[14*idx +: 14];
    end else if (idx >= `PMP_DIA_CID_FIRST && idx <= `PMP_DIA_CID_LAST) begin
      data = CUSTOMER_ID[14*cid +: 14];
    end else if (idx == `PMP_DIA_REF1X) begin
      data = REF_MV_1X;
    end else if (idx == `PMP_DIA_REF2X) begin
      data = REF_MV_2X;
    end else if (idx == `PMP_DIA_REF4X) begin
      data = REF_MV_4X;
    end
  end
endmodule

// [rtl/pmp_partition_map.sv]
// Program counter, address wrap, partitions, indirect read, AXI4-Lite
// Contract
// - Program counter is 15 bits, 32K words of 14 bits.
// - Addresses above implemented size wrap into implemented space.
// - Reset starts at 0000h; interrupt entry loads 0004h.
// - Pointer high bit 7 set makes indirect reads use program memory.
// - Indirect move to W returns only the low eight bits.
// - Indirect writes into program memory change nothing.
// - Indirect program memory reads take one extra cycle.
// - Both enables at 1 make all user flash application block.
// - Storage area enable cleared reserves the last 128 words.
// - Fetches from an enabled storage area are invalid execution.
// - Write to protected block is dropped and sets write error.
// - Invalid execution causes violation reset and clears its flag.
// - Enabled boot block spans 0000h to size-selected last address.
// - Application, boot, config each have their own write protect.
// - Information area from 8100h is readable, never writable.
// - Info area holds factory id, reserved, customer id, reserved.
// - Words 8118h to 811Ah hold reference millivolts per gain.
// - Size field selects boot end address, capped at half memory.
// - Size field changes only while boot block disabled; bulk erase resets it to 7 even while the block is enabled.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "pmp_cfg.svh"
module pmp_partition_map
  import pmp_pkg::*;
#(
  parameter int PM_WORDS = `PMP_PM_WORDS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pc_step,
  input wire logic pc_jump,
  input wire logic [14:0] pc_jump_addr,
  input wire logic int_entry,
  input wire logic fetch_exec,
  output logic [14:0] prog_counter,
  output logic [14:0] fetch_addr,
  output logic exec_violation_reset,
  output logic exec_violation_flag,
  input wire logic ind_req,
  input wire logic ind_write,
  input wire logic [7:0] indirect_pointer_high,
  input wire logic [7:0] indirect_pointer_low,
  output logic [7:0] ind_rdata,
  output logic ind_done,
  output logic ind_stall,
  output logic ind_write_dropped,
  input wire logic nvm_wr_req,
  input wire logic [15:0] nvm_wr_addr,
  input wire logic [13:0] nvm_wr_data,
  output logic nvm_write_error_flag,
  output logic flash_rd_en,
  output logic [14:0] flash_rd_addr,
  input wire logic [13:0] flash_rdata,
  output logic flash_wr_en,
  output logic [15:0] flash_wr_addr,
  output logic [13:0] flash_wr_data
);
  localparam logic [14:0] PM_MASK = 15'(PM_WORDS - 1);
  localparam logic [14:0] BOOT_CAP = 15'(PM_WORDS / 2 - 1);

  if (PM_WORDS != 2048 && PM_WORDS != 4096) begin : g_bad_size
    $error("PM_WORDS must be 2048 or 4096");
  end

  pmp_state_type q;
  pmp_state_type d;
  logic [14:0] boot_last;
  logic [15:0] w_addr;
  logic w_app, w_boot, w_cfg, w_ro;
  logic f_saf;
  logic w_reject;
  logic [13:0] info_data;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  always_comb begin
    case (q.boot_block_size_sel)
      3'h7: boot_last = `PMP_BB_END_111;
      3'h6: boot_last = `PMP_BB_END_110;
      3'h5: boot_last = `PMP_BB_END_101;
      3'h4: boot_last = `PMP_BB_END_100;
      3'h3: boot_last = `PMP_BB_END_011;
      default: boot_last = `PMP_BB_END_LOW;
    endcase
    if (boot_last > BOOT_CAP) begin
      boot_last = BOOT_CAP;
    end
  end

  assign w_addr = nvm_wr_addr[15] ? nvm_wr_addr :
                  {1'b0, nvm_wr_addr[14:0] & PM_MASK};

  pmp_region_decode #(.PM_WORDS(PM_WORDS)) u_wr_decode (
    .addr(w_addr),
    .boot_last(boot_last),
    .boot_en_n(q.boot_en_n),
    .saf_en_n(q.saf_en_n),
    .in_app(w_app),
    .in_boot(w_boot),
    .in_saf(),
    .in_cfg(w_cfg),
    .in_ro(w_ro)
  );

  pmp_region_decode #(.PM_WORDS(PM_WORDS)) u_fetch_decode (
    .addr({1'b0, q.fetch_addr}),
    .boot_last(boot_last),
    .boot_en_n(q.boot_en_n),
    .saf_en_n(q.saf_en_n),
    .in_app(),
    .in_boot(),
    .in_saf(f_saf),
    .in_cfg(),
    .in_ro()
  );

  pmp_info_rom u_info (
    .idx(s_axi_araddr[6:2]),
    .data(info_data)
  );

  assign w_reject = (w_app & ~q.app_wp_n) | (w_boot & ~q.boot_wp_n) |
                    (w_cfg & ~q.cfg_wp_n) | w_ro;

  always_comb begin
    ctrl_rd = 32'h00000000;
    ctrl_rd[`PMP_B_BOOT_BLOCK_SIZE_SEL +: 3] = q.boot_block_size_sel;
    ctrl_rd[`PMP_B_BOOT_EN_N] = q.boot_en_n;
    ctrl_rd[`PMP_B_SAF_EN_N] = q.saf_en_n;
    ctrl_rd[`PMP_B_APP_WP_N] = q.app_wp_n;
    ctrl_rd[`PMP_B_BOOT_WP_N] = q.boot_wp_n;
    ctrl_rd[`PMP_B_CFG_WP_N] = q.cfg_wp_n;
    stat_rd = 32'h00000000;
    stat_rd[`PMP_B_WERR] = q.wr_err;
    stat_rd[`PMP_B_EXEC] = q.exec_ok;
  end

  always_comb begin
    d = q;
    d.flash_rd = 1'b0;
    d.flash_wr = 1'b0;
    d.ind_done = 1'b0;
    d.ind_wr_drop = 1'b0;
    d.viol_rst = 1'b0;

    if (int_entry) begin
      d.pc = `PMP_INT_VEC;
    end else if (pc_jump) begin
      d.pc = pc_jump_addr;
    end else if (pc_step) begin
      d.pc = q.pc + `PMP_PC_ONE;
    end
    if (fetch_exec && f_saf) begin
      d.viol_rst = 1'b1;
      d.pc = `PMP_RESET_VEC;
    end
    d.fetch_addr = d.pc & PM_MASK;

    case (q.ind)
      PMP_IND_IDLE: begin
        if (ind_req && indirect_pointer_high[`PMP_PTR_PM_BIT]) begin
          if (ind_write) begin
            d.ind_wr_drop = 1'b1;
          end else begin
            d.flash_rd = 1'b1;
            d.flash_addr = {indirect_pointer_high[6:0],
                            indirect_pointer_low} & PM_MASK;
            d.ind_stall = 1'b1;
            d.ind = PMP_IND_FETCH;
          end
        end
      end
      PMP_IND_FETCH: begin
        d.ind_rdata = flash_rdata[7:0];
        d.ind_done = 1'b1;
        d.ind_stall = 1'b0;
        d.ind = PMP_IND_IDLE;
      end
      default: begin
        d.ind_stall = 1'b0;
        d.ind = PMP_IND_IDLE;
      end
    endcase

    // Write address and data may arrive in either order
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awrdy) begin
      d.awok = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wrdy) begin
      d.wok = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (d.awok && d.wok && !d.bvalid) begin
      d.awok = 1'b0;
      d.wok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `PMP_RESP_OKAY;
      case (d.awaddr)
        `PMP_OFS_CTRL: begin
          if (d.wstrb[0]) begin
            if (q.boot_en_n) begin
              d.boot_block_size_sel = d.wdata[`PMP_B_BOOT_BLOCK_SIZE_SEL +: 3];
            end
            d.boot_en_n = d.wdata[`PMP_B_BOOT_EN_N];
            d.saf_en_n = d.wdata[`PMP_B_SAF_EN_N];
            // Protection only clears; bulk erase restores it
            d.app_wp_n = q.app_wp_n & d.wdata[`PMP_B_APP_WP_N];
          end
          if (d.wstrb[1]) begin
            d.boot_wp_n = q.boot_wp_n & d.wdata[`PMP_B_BOOT_WP_N];
            d.cfg_wp_n = q.cfg_wp_n & d.wdata[`PMP_B_CFG_WP_N];
          end
          if (d.wstrb[3] && d.wdata[`PMP_B_BULK]) begin
            d.boot_block_size_sel = `PMP_BOOT_BLOCK_SIZE_SEL_RST;
            d.boot_en_n = 1'b1;
            d.saf_en_n = 1'b1;
            d.app_wp_n = 1'b1;
            d.boot_wp_n = 1'b1;
            d.cfg_wp_n = 1'b1;
          end
        end
        `PMP_OFS_STATUS: begin
          if (d.wstrb[0] && d.wdata[`PMP_B_WERR]) begin
            d.wr_err = 1'b0;
          end
          if (d.wstrb[0] && d.wdata[`PMP_B_EXEC]) begin
            d.exec_ok = 1'b1;
          end
        end
        `PMP_OFS_BOOTEND, `PMP_OFS_PC: begin
          d.bresp = `PMP_RESP_OKAY;
        end
        default: begin
          // Writes into the info window also land here
          d.bresp = `PMP_RESP_SLVERR;
        end
      endcase
    end
    d.awrdy = ~d.awok;
    d.wrdy = ~d.wok;

    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp = `PMP_RESP_OKAY;
      d.rdata = 32'h00000000;
      if (s_axi_araddr[`PMP_DIA_WIN_BIT]) begin
        d.rdata = {18'h00000, info_data};
      end else begin
        case (s_axi_araddr)
          `PMP_OFS_CTRL: d.rdata = ctrl_rd;
          `PMP_OFS_STATUS: d.rdata = stat_rd;
          `PMP_OFS_BOOTEND: d.rdata = {17'h00000, boot_last};
          `PMP_OFS_PC: d.rdata = {17'h00000, q.pc};
          default: d.rresp = `PMP_RESP_SLVERR;
        endcase
      end
    end
    d.arrdy = ~d.rvalid;

    if (nvm_wr_req) begin
      if (w_reject) begin
        // dropped, error set wins over clear
        d.wr_err = 1'b1;
      end else begin
        d.flash_wr = 1'b1;
        d.flash_wr_addr = w_addr;
        d.flash_wdata = nvm_wr_data;
      end
    end
    if (fetch_exec && f_saf) begin
      d.exec_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.pc <= `PMP_RESET_VEC;
      q.fetch_addr <= `PMP_RESET_VEC;
      q.boot_block_size_sel <= `PMP_BOOT_BLOCK_SIZE_SEL_RST;
      q.boot_en_n <= 1'b1;
      q.saf_en_n <= 1'b1;
      q.app_wp_n <= 1'b1;
      q.boot_wp_n <= 1'b1;
      q.cfg_wp_n <= 1'b1;
      q.exec_ok <= 1'b1;
      q.ind <= PMP_IND_IDLE;
      q.awrdy <= 1'b1;
      q.wrdy <= 1'b1;
      q.arrdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awrdy;
  assign s_axi_wready = q.wrdy;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arrdy;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign prog_counter = q.pc;
  assign fetch_addr = q.fetch_addr;
  assign exec_violation_reset = q.viol_rst;
  assign exec_violation_flag = q.exec_ok;
  assign ind_rdata = q.ind_rdata;
  assign ind_done = q.ind_done;
  assign ind_stall = q.ind_stall;
  assign ind_write_dropped = q.ind_wr_drop;
  assign nvm_write_error_flag = q.wr_err;
  assign flash_rd_en = q.flash_rd;
  assign flash_rd_addr = q.flash_addr;
  assign flash_wr_en = q.flash_wr;
  assign flash_wr_addr = q.flash_wr_addr;
  assign flash_wr_data = q.flash_wdata;
endmodule

// [verif/pmp_partition_map_asserts.sv]
// Concurrent checks on the partition map ports
`timescale 1ns/10ps
module pmp_partition_map_asserts #(
  parameter int PM_WORDS = 4096
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pc_step,
  input wire logic pc_jump,
  input wire logic int_entry,
  input wire logic fetch_exec,
  input wire logic [14:0] prog_counter,
  input wire logic [14:0] fetch_addr,
  input wire logic exec_violation_reset,
  input wire logic exec_violation_flag,
  input wire logic ind_req,
  input wire logic ind_write,
  input wire logic [7:0] indirect_pointer_high,
  input wire logic [7:0] ind_rdata,
  input wire logic ind_done,
  input wire logic ind_stall,
  input wire logic ind_write_dropped,
  input wire logic nvm_wr_req,
  input wire logic [15:0] nvm_wr_addr,
  input wire logic nvm_write_error_flag,
  input wire logic flash_rd_en,
  input wire logic [13:0] flash_rdata,
  input wire logic flash_wr_en
);
  logic [7:0] fl_q;
  always_ff @(posedge aclk) begin
    fl_q <= flash_rdata[7:0];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pc_step: assert property (pc_step && !pc_jump && !int_entry
    && !fetch_exec |=> prog_counter == $past(prog_counter) + 15'h0001)
    else $error("pc step wrong");
  a_fetch_wrap: assert property (
    fetch_addr == (prog_counter & 15'(PM_WORDS - 1)))
    else $error("fetch address not wrapped");
  a_int_vector: assert property (int_entry && !fetch_exec
    |=> prog_counter == 15'h0004) else $error("interrupt vector wrong");
  a_viol_effect: assert property (exec_violation_reset
    |-> prog_counter == 15'h0000 && !exec_violation_flag)
    else $error("violation reset effect wrong");
  a_viol_cause: assert property (exec_violation_reset |->
    $past(fetch_exec) && $past(fetch_addr) >= 15'(PM_WORDS - 128)
    ##1 !exec_violation_reset) else $error("violation without cause");
  a_ind_timing: assert property (ind_req && !ind_write
    && indirect_pointer_high[7] && !ind_stall
    |=> ind_stall && flash_rd_en ##1 ind_done && !ind_stall)
    else $error("indirect read timing wrong");
  a_ind_data: assert property (ind_done |-> ind_rdata == fl_q)
    else $error("indirect data wrong");
  a_ind_refuse: assert property (ind_req
    && !indirect_pointer_high[7] |=> !flash_rd_en && !ind_write_dropped)
    else $error("data space access reached flash");
  a_ind_wdrop: assert property (ind_req && ind_write
    && indirect_pointer_high[7] && !nvm_wr_req && !ind_stall
    |=> ind_write_dropped && !flash_wr_en)
    else $error("indirect write not dropped");
  a_info_ro: assert property (nvm_wr_req
    && nvm_wr_addr[15:8] == 8'h81 |=> !flash_wr_en && nvm_write_error_flag)
    else $error("info area write accepted");
endmodule

// [verif/pmp_flash_model.sv]
// Flash array stand-in with a combinational read port
`timescale 1ns/10ps
module pmp_flash_model (
  input wire logic aclk,
  input wire logic rd_en,
  input wire logic [14:0] rd_addr,
  input wire logic wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [13:0] wr_data,
  output logic [13:0] rdata
);
  logic [13:0] mem [4096];
  logic [13:0] junk_q = 14'h1555;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = {i[5:0], i[7:0] ^ {i[11:8], i[11:8]}};
    end
  end
  // Idle port toggles so a stale word never looks valid
  always @(posedge aclk) begin
    junk_q <= ~junk_q;
    if (wr_en && !wr_addr[15]) begin
      mem[wr_addr[11:0]] <= wr_data;
    end
  end
  assign rdata = rd_en ? mem[rd_addr[11:0]] : junk_q;
endmodule

// [verif/tb.sv]
// Self-checking bench for the partition map
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("unexpected t=%0t got=%0h exp=%0h", $time, g, e); \
  end end
module tb;
  localparam int PMW = 4096;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, exec_violation_reset, exec_violation_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic pc_step = 1'h0, pc_jump = 1'h0, int_entry = 1'h0;
  logic fetch_exec = 1'h0, ind_req = 1'h0, ind_write = 1'h0;
  logic [14:0] pc_jump_addr = 15'h0000, prog_counter, fetch_addr, a;
  logic [7:0] indirect_pointer_high = 8'h00, indirect_pointer_low = 8'h00;
  logic [7:0] ind_rdata, hv;
  logic ind_done, ind_stall, ind_write_dropped, nvm_wr_req = 1'h0;
  logic [15:0] nvm_wr_addr = 16'h0000, flash_wr_addr;
  logic [13:0] nvm_wr_data = 14'h0000, flash_rdata, flash_wr_data;
  logic nvm_write_error_flag, flash_rd_en, flash_wr_en;
  logic [14:0] flash_rd_addr;
  integer seed, n_fail = 0, samples_checked = 0, k, n;

  pmp_partition_map #(.PM_WORDS(PMW)) u_dut (.*);
  pmp_flash_model u_flash (.aclk(aclk), .rd_en(flash_rd_en),
    .rd_addr(flash_rd_addr), .wr_en(flash_wr_en), .wr_addr(flash_wr_addr),
    .wr_data(flash_wr_data), .rdata(flash_rdata));

  initial begin
    forever #25 aclk = ~aclk;
  end

  function automatic logic [7:0] flo(input logic [11:0] x);
    return x[7:0] ^ {x[11:8], x[11:8]};
  endfunction

  function automatic logic [13:0] info_exp(input int i);
    if (i <= 8) return 14'h1A5C;
    if (i >= 10 && i <= 17) return 14'h3FFF;
    if (i >= 24 && i <= 26) return 14'h0400 << (i - 24);
    return 14'h0000;
  endfunction

  task conclude;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task axw(input logic [7:0] ad, input logic [31:0] dv);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 40 && !s_axi_bvalid; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    if (i == 40) begin
      n_fail++;
      conclude;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task axr(input logic [7:0] ad);
    int i;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (i = 0; i < 40 && !s_axi_rvalid; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    if (i == 40) begin
      n_fail++;
      conclude;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task jmp(input logic [14:0] ad);
    @(posedge aclk);
    pc_jump <= 1'h1;
    pc_jump_addr <= ad;
    @(posedge aclk);
    pc_jump <= 1'h0;
  endtask

  task fx(input logic [14:0] ad, input logic v);
    jmp(ad);
    fetch_exec <= 1'h1;
    @(posedge aclk);
    fetch_exec <= 1'h0;
    @(posedge aclk);
    `CHK(exec_violation_reset, v)
    if (v) `CHK({prog_counter, exec_violation_flag}, 16'h0000)
  endtask

  task ind(input logic [7:0] h, input logic [7:0] l, input logic w);
    @(posedge aclk);
    ind_req <= 1'h1;
    ind_write <= w;
    indirect_pointer_high <= h;
    indirect_pointer_low <= l;
    @(posedge aclk);
    ind_req <= 1'h0;
    @(posedge aclk);
    if (h[7] && w) `CHK(ind_write_dropped, 1'h1)
    if (h[7] && !w) `CHK(ind_stall, 1'h1)
    if (h[7] && !w) `CHK(flash_rd_addr, {3'h0, h[3:0], l})
    @(posedge aclk);
    `CHK(ind_done, h[7] && !w)
    if (h[7] && !w) `CHK(ind_rdata, flo({h[3:0], l}))
  endtask

  task nv(input logic [15:0] ad, input logic ok);
    @(posedge aclk);
    nvm_wr_req <= 1'h1;
    nvm_wr_addr <= ad;
    nvm_wr_data <= {ad[5:0], flo(ad[11:0])};
    @(posedge aclk);
    nvm_wr_req <= 1'h0;
    @(posedge aclk);
    `CHK({flash_wr_en, nvm_write_error_flag}, {ok, !ok})
    if (ok) `CHK(flash_wr_addr, ad[15] ? ad : ad & 16'(PMW - 1))
    if (ok) `CHK(flash_wr_data, {ad[5:0], flo(ad[11:0])})
    axw(8'h04, 32'h00000001);
  endtask

  initial begin
    seed = 32'h0D1A;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK({prog_counter, exec_violation_flag}, 16'h0001)
    axr(8'h00);
    `CHK(d & 32'h0000039F, 32'h0000039F)
    axr(8'h08);
    `CHK(d[14:0], 15'h01FF)
    axw(8'h80, 32'h00000000);
    `CHK(r, 2'h2)
    for (k = 0; k < 32; k++) begin
      axr({1'h1, k[4:0], 2'h0});
      `CHK(d[13:0], info_exp(k))
      `CHK(r, 2'h0)
    end
    for (k = 0; k < 6; k++) begin
      a = (k == 0) ? 15'h7FFE : 15'($random(seed));
      n = 1 + ($random(seed) & 7);
      jmp(a);
      pc_step <= 1'h1;
      repeat (n) @(posedge aclk);
      pc_step <= 1'h0;
      @(posedge aclk);
      `CHK(prog_counter, 15'(a + n))
    end
    @(posedge aclk);
    int_entry <= 1'h1;
    pc_jump <= 1'h1;
    @(posedge aclk);
    int_entry <= 1'h0;
    pc_jump <= 1'h0;
    @(posedge aclk);
    `CHK(prog_counter, 15'h0004)
    for (k = 0; k < 12; k++) begin
      hv = (k == 0) ? 8'hFF : 8'($random(seed)) | ((k % 3) ? 8'h80 : 8'h00);
      ind(hv, (k == 0) ? 8'hFF : 8'($random(seed)), k % 4 == 3);
    end
    fx(15'h7F80, 1'h0);
    nv(16'h0300, 1'h1);
    nv(16'h7300, 1'h1);
    nv(16'h8008, 1'h1);
    nv(16'h8100, 1'h0);
    nv(16'h811A, 1'h0);
    axw(8'h00, 32'h00000297);
    `CHK(r, 2'h0)
    nv(16'h01FF, 1'h0);
    nv(16'h0200, 1'h1);
    axw(8'h00, 32'h00000296);
    axr(8'h08);
    `CHK(d[14:0], 15'h01FF)
    axw(8'h00, 32'h00000216);
    nv(16'h0200, 1'h0);
    axw(8'h00, 32'h00000016);
    nv(16'h8008, 1'h0);
    axw(8'h00, 32'h80000000);
    axr(8'h00);
    `CHK(d & 32'h0000039F, 32'h0000039F)
    s_axi_wstrb <= 4'h1;
    axw(8'h00, 32'h0000009C);
    s_axi_wstrb <= 4'hF;
    axr(8'h00);
    `CHK(d & 32'h0000039F, 32'h0000039C)
    axr(8'h08);
    `CHK(d[14:0], 15'h07FF)
    axw(8'h00, 32'h0000038F);
    fx(15'h0F7F, 1'h0);
    fx(15'h7F80, 1'h1);
    axw(8'h04, 32'h00000002);
    axr(8'h04);
    `CHK(d[1], 1'h1)
    conclude;
  end
endmodule
bind pmp_partition_map pmp_partition_map_asserts #(.PM_WORDS(PM_WORDS))
  u_chk (.*);
